/* inc/pod_pkg.sv */
// Constants, register map and encodings of the emulator pod control block
package pod_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses of 32-bit words)
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_UPPER  = 4'h4;
  localparam logic [3:0] OFS_DATA   = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // ----------------------------------------------------------------------
  // Configuration latch fields and reset value
  // ----------------------------------------------------------------------
  localparam int          CFG_CLK_INTERNAL = 0;
  localparam int          CFG_SEL_LO       = 1;
  localparam int          CFG_PRECEDENCE   = 3;
  localparam int          CFG_RUN          = 4;
  localparam logic [15:0] CFG_RESET        = 16'h0001;

  // Data port targets picked by the two select bits
  localparam logic [1:0] SEL_SELF_CHECK = 2'h0;
  localparam logic [1:0] SEL_MAP_RAM    = 2'h1;
  localparam logic [1:0] SEL_JAM_RAM    = 2'h2;
  localparam logic [1:0] SEL_VERIFY     = 2'h3;

  // Field positions in data port writes
  localparam int MAP_LOW_LSB  = 0;
  localparam int MAP_USER_BIT = 8;

  // Status word fields
  localparam int ST_IN_CIRCUIT = 0;
  localparam int ST_QUEUE_MODE = 1;
  localparam int ST_BREAK      = 2;
  localparam int ST_TGT_GRANT  = 3;
  localparam int ST_EMU_GRANT  = 4;
  localparam int ST_HOLD       = 5;

  // ----------------------------------------------------------------------
  // Cycle status line encodings
  // ----------------------------------------------------------------------
  localparam logic [2:0] CS_INTA    = 3'h0;
  localparam logic [2:0] CS_IO_RD   = 3'h1;
  localparam logic [2:0] CS_IO_WR   = 3'h2;
  localparam logic [2:0] CS_HALT    = 3'h3;
  localparam logic [2:0] CS_FETCH   = 3'h4;
  localparam logic [2:0] CS_MEM_RD  = 3'h5;
  localparam logic [2:0] CS_MEM_WR  = 3'h6;
  localparam logic [2:0] CS_PASSIVE = 3'h7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int ON_POD_OSC_MHZ = 16;
  localparam int SYS_CLK_MHZ    = 200;

  // Pointer area compare: address bits 5 through 19 all zero
  localparam int VEC_LSB = 5;
  localparam int VEC_MSB = 19;

endpackage

/* verilog/emulator_pod_break_control.sv */
// Emulator pod control: gating, strobes, arbiter, mapping, break jamming
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
module emulator_pod_break_control #(
  parameter int CS_WIDTH    = 10,
  parameter int TMR_WIDTH   = 2,
  parameter int DMA_WIDTH   = 2,
  parameter int IRQ_WIDTH   = 4,
  parameter int JAM_DEPTH   = 16,
  parameter int MAP_ENTRIES = 256
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Avalon-MM register slave
  input  wire logic [3:0]           address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // Target side inputs (asynchronous)
  input  wire logic                 in_circuit_detector,
  input  wire logic [DMA_WIDTH-1:0] tgt_dma_req,
  input  wire logic [TMR_WIDTH-1:0] tgt_timer_in,
  input  wire logic [IRQ_WIDTH-1:0] tgt_int_req,
  input  wire logic                 tgt_nmi,
  input  wire logic                 tgt_bus_req,
  // Gated inputs toward processor
  output logic      [DMA_WIDTH-1:0] proc_dma_req,
  output logic      [TMR_WIDTH-1:0] proc_timer_in,
  output logic      [IRQ_WIDTH-1:0] proc_int_req,
  output logic                      proc_nmi,
  // Forwarded processor outputs
  input  wire logic [CS_WIDTH-1:0]  proc_chip_sel_b,
  input  wire logic [TMR_WIDTH-1:0] proc_timer_out,
  output logic      [CS_WIDTH-1:0]  tgt_chip_sel_b,
  output logic      [TMR_WIDTH-1:0] tgt_timer_out,
  // Clock source select
  output logic                      proc_clk_internal,
  // Processor bus
  input  wire logic [2:0]           cycle_status_lines,
  input  wire logic                 queue_state_bit0,
  input  wire logic                 queue_state_bit1,
  input  wire logic [19:0]          proc_addr,
  output logic      [15:0]          jam_data,
  output logic                      jam_drive,
  // Bus release arbiter and break request
  input  wire logic                 emu_bus_req,
  input  wire logic                 break_request,
  input  wire logic                 proc_hlda,
  output logic                      proc_hold,
  output logic                      tgt_bus_grant,
  output logic                      emu_bus_grant,
  // Target strobe pins
  input  wire logic                 tgt_rd_b_in,
  output logic                      tgt_rd_b_out,
  output logic                      tgt_rd_b_oe,
  output logic                      tgt_wr_qs1,
  output logic                      tgt_ale_qs0,
  output logic                      regenerated_latch_strobe,
  // Transceiver controls
  output logic                      tgt_xcvr_oe,
  output logic                      tgt_xcvr_to_target,
  output logic                      card_xcvr_oe,
  output logic                      card_xcvr_to_card
);
  import pod_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int NSYNC = DMA_WIDTH + TMR_WIDTH + IRQ_WIDTH + 4;
  logic [NSYNC-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
  logic [NSYNC-1:0] raw_in;
  assign raw_in = {tgt_dma_req, tgt_timer_in, tgt_int_req, tgt_nmi,
                   tgt_bus_req, tgt_rd_b_in, in_circuit_detector};

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg  <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= (sync2_reg & sync3_reg) |
                   (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  logic in_circuit, tgt_rd_low, tgt_breq_s, tgt_nmi_s;
  logic       own_quiet, rd_low_reg;
  logic [4:0] own_low_reg;
  assign in_circuit = filt_reg[0];
  // Our own low drive echoes back through the synchroniser; hold the mode
  assign own_quiet  = own_low_reg == 5'h00 &&
                      !(tgt_rd_b_oe && !tgt_rd_b_out);
  assign tgt_rd_low = own_quiet ? ~filt_reg[1] : rd_low_reg;

  // Own drive history and last trusted read-line level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      own_low_reg <= 5'h00;
      rd_low_reg  <= 1'b0;
    end else begin
      own_low_reg <= {own_low_reg[3:0], tgt_rd_b_oe & ~tgt_rd_b_out};
      rd_low_reg  <= tgt_rd_low;
    end
  end
  assign tgt_breq_s = filt_reg[2];
  assign tgt_nmi_s  = filt_reg[3] & in_circuit;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] config_reg;
  logic [3:0]  upper_reg;
  logic [15:0] self_check_reg;
  logic [2:0]  verify_reg;
  logic        ack_reg;
  logic        map_ram [MAP_ENTRIES];
  logic [15:0] jam_ram [JAM_DEPTH];

  logic [1:0] sel;
  logic       run_mode, wr_take, rd_take, precedence;
  assign sel        = config_reg[CFG_SEL_LO +: 2];
  assign run_mode   = config_reg[CFG_RUN];
  assign precedence = config_reg[CFG_PRECEDENCE];

  // Single wait cycle; write data lands at the release edge, read data one edge earlier
  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_take     = write & ack_reg;
  assign rd_take     = read & ~ack_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) ack_reg <= 1'b0;
    else        ack_reg <= (read | write) & ~ack_reg;
  end

  // Configuration latch
  always_ff @(posedge clk) begin
    if (!rst_b) config_reg <= CFG_RESET;
    else if (wr_take && address == OFS_CONFIG)
      config_reg <= writedata[15:0];
  end

  // Upper address latch, loaded only outside runs
  always_ff @(posedge clk) begin
    if (!rst_b) upper_reg <= 4'h0;
    else if (wr_take && address == OFS_UPPER && !run_mode)
      upper_reg <= writedata[11:8];
  end

  // Self-check latch, also the monitor compare address
  always_ff @(posedge clk) begin
    if (!rst_b) self_check_reg <= 16'h0000;
    else if (wr_take && address == OFS_DATA && sel == SEL_SELF_CHECK)
      self_check_reg <= writedata[15:0];
  end

  // Mapping and jam RAM programming
  logic [7:0] map_wr_idx;
  assign map_wr_idx = {upper_reg, writedata[MAP_LOW_LSB +: 4]};
  always_ff @(posedge clk) begin
    if (wr_take && address == OFS_DATA && !run_mode) begin
      if (sel == SEL_MAP_RAM)
        map_ram[map_wr_idx] <= writedata[MAP_USER_BIT];
      if (sel == SEL_JAM_RAM)
        jam_ram[upper_reg] <= writedata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Status decode and strobe generation
  // ----------------------------------------------------------------------
  function automatic logic is_read(input logic [2:0] s);
    return s == CS_INTA || s == CS_IO_RD || s == CS_FETCH ||
           s == CS_MEM_RD;
  endfunction

  function automatic logic is_write(input logic [2:0] s);
    return s == CS_IO_WR || s == CS_MEM_WR;
  endfunction

  typedef enum logic [1:0] {CYC_IDLE, CYC_LOOKUP, CYC_ACTIVE} cyc_e;
  cyc_e        cyc_reg;
  logic [2:0]  status_prev_reg;
  logic        cycle_start;
  logic        rd_lat_reg, wr_lat_reg, fetch_lat_reg, user_reg;
  logic [19:0] addr_lat_reg;
  logic        mon_eq, vec_eq;

  // A cycle starts when status leaves passive for any state but halt
  assign cycle_start = status_prev_reg == CS_PASSIVE &&
                       cycle_status_lines != CS_PASSIVE &&
                       cycle_status_lines != CS_HALT;

  always_ff @(posedge clk) begin
    if (!rst_b) status_prev_reg <= CS_PASSIVE;
    else        status_prev_reg <= cycle_status_lines;
  end

  // Regenerated latch strobe and latched read/write decode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regenerated_latch_strobe <= 1'b0;
      addr_lat_reg             <= 20'h00000;
      rd_lat_reg               <= 1'b0;
      wr_lat_reg               <= 1'b0;
      fetch_lat_reg            <= 1'b0;
    end else begin
      regenerated_latch_strobe <= cycle_start;
      if (cycle_start) begin
        addr_lat_reg  <= proc_addr;
        rd_lat_reg    <= is_read(cycle_status_lines);
        wr_lat_reg    <= is_write(cycle_status_lines);
        fetch_lat_reg <= cycle_status_lines == CS_FETCH;
      end
    end
  end

  // Cycle phase: lookup one cycle, then qualified strobes until passive
  always_ff @(posedge clk) begin
    if (!rst_b) cyc_reg <= CYC_IDLE;
    else begin
      case (cyc_reg)
        CYC_IDLE:   if (cycle_start) cyc_reg <= CYC_LOOKUP;
        CYC_LOOKUP: cyc_reg <= CYC_ACTIVE;
        CYC_ACTIVE:
          if (cycle_status_lines == CS_PASSIVE) cyc_reg <= CYC_IDLE;
        default:    cyc_reg <= CYC_IDLE;
      endcase
    end
  end

  // Comparators on the latched address
  assign mon_eq = addr_lat_reg[15:0] == self_check_reg;
  assign vec_eq = addr_lat_reg[VEC_MSB:VEC_LSB] == '0;

  // Map lookup and verify latch, both taken in the lookup phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      user_reg   <= 1'b0;
      verify_reg <= 3'h0;
    end else if (cyc_reg == CYC_LOOKUP) begin
      user_reg   <= map_ram[addr_lat_reg[19:12]];
      verify_reg <= {map_ram[addr_lat_reg[19:12]], mon_eq, vec_eq};
    end
  end

  logic active, user_rd, user_wr, emu_rd, emu_wr;
  assign active  = cyc_reg == CYC_ACTIVE;
  assign user_rd = active & rd_lat_reg & user_reg;
  assign user_wr = active & wr_lat_reg & user_reg;
  assign emu_rd  = active & rd_lat_reg & ~user_reg;
  assign emu_wr  = active & wr_lat_reg & ~user_reg;

  // ----------------------------------------------------------------------
  // Target strobe pins and transceivers
  // ----------------------------------------------------------------------
  logic queue_mode;
  assign queue_mode = in_circuit & tgt_rd_low;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tgt_rd_b_out       <= 1'b1;
      tgt_rd_b_oe        <= 1'b0;
      tgt_wr_qs1         <= 1'b1;
      tgt_ale_qs0        <= 1'b0;
      tgt_xcvr_oe        <= 1'b0;
      tgt_xcvr_to_target <= 1'b1;
    end else begin
      if (queue_mode) begin
        tgt_rd_b_oe <= 1'b0;
        tgt_ale_qs0 <= queue_state_bit0;
        tgt_wr_qs1  <= queue_state_bit1;
      end else begin
        tgt_rd_b_oe <= in_circuit;
        tgt_ale_qs0 <= cycle_start;
        tgt_wr_qs1  <= ~user_wr;
      end
      tgt_rd_b_out       <= ~user_rd;
      tgt_xcvr_oe        <= user_rd | user_wr | cycle_start;
      tgt_xcvr_to_target <= ~user_rd;
    end
  end

  // Card side transceivers: cycles in runs, card strobes otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      card_xcvr_oe      <= 1'b0;
      card_xcvr_to_card <= 1'b0;
    end else if (run_mode) begin
      card_xcvr_oe      <= emu_rd | emu_wr | cycle_start;
      card_xcvr_to_card <= ~emu_rd;
    end else begin
      card_xcvr_oe      <= read | write;
      card_xcvr_to_card <= read;
    end
  end

  // ----------------------------------------------------------------------
  // Bus release arbiter
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ARB_IDLE, ARB_ASK, ARB_GRANT, ARB_DROP} arb_e;
  arb_e arb_reg;
  logic winner_tgt_reg, want;
  assign want = winner_tgt_reg ? tgt_breq_s & in_circuit : emu_bus_req;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arb_reg        <= ARB_IDLE;
      winner_tgt_reg <= 1'b0;
    end else begin
      case (arb_reg)
        ARB_IDLE:
          if (tgt_breq_s && in_circuit) begin
            winner_tgt_reg <= 1'b1;
            arb_reg        <= ARB_ASK;
          end else if (emu_bus_req) begin
            winner_tgt_reg <= 1'b0;
            arb_reg        <= ARB_ASK;
          end
        ARB_ASK:
          if (!want)          arb_reg <= ARB_DROP;
          else if (proc_hlda) arb_reg <= ARB_GRANT;
        ARB_GRANT: if (!want) arb_reg <= ARB_DROP;
        ARB_DROP:  if (!proc_hlda) arb_reg <= ARB_IDLE;
        default:   arb_reg <= ARB_IDLE;
      endcase
    end
  end

  assign proc_hold     = arb_reg == ARB_ASK || arb_reg == ARB_GRANT;
  assign tgt_bus_grant = arb_reg == ARB_GRANT && winner_tgt_reg;
  assign emu_bus_grant = arb_reg == ARB_GRANT && !winner_tgt_reg;

  // ----------------------------------------------------------------------
  // Break controller and instruction jamming
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {BRK_IDLE, BRK_NMI, BRK_JAM} brk_e;
  brk_e        brk_reg;
  logic [3:0]  jam_addr_reg;
  logic        tgt_first, jam_end;
  assign tgt_first = precedence & tgt_nmi_s;
  assign jam_end   = cyc_reg == CYC_ACTIVE &&
                     cycle_status_lines == CS_PASSIVE && fetch_lat_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      brk_reg      <= BRK_IDLE;
      jam_addr_reg <= 4'h0;
    end else begin
      case (brk_reg)
        BRK_IDLE:
          if (break_request && !tgt_first) begin
            brk_reg      <= BRK_NMI;
            jam_addr_reg <= 4'h0;
          end
        BRK_NMI: if (cycle_start) brk_reg <= BRK_JAM;
        BRK_JAM:
          if (jam_end) begin
            if (mon_eq || jam_addr_reg == 4'(JAM_DEPTH - 1))
              brk_reg <= BRK_IDLE;
            else
              jam_addr_reg <= jam_addr_reg + 4'h1;
          end
        default: brk_reg <= BRK_IDLE;
      endcase
    end
  end

  // Jammed word is driven during fetch reads of a break
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      jam_data  <= 16'h0000;
      jam_drive <= 1'b0;
      proc_nmi  <= 1'b0;
    end else begin
      jam_data  <= jam_ram[jam_addr_reg];
      jam_drive <= brk_reg == BRK_JAM && active && fetch_lat_reg;
      proc_nmi  <= tgt_nmi_s || brk_reg == BRK_NMI;
    end
  end

  // ----------------------------------------------------------------------
  // Pass-through, gating and read-back
  // ----------------------------------------------------------------------
  assign tgt_chip_sel_b    = proc_chip_sel_b;
  assign tgt_timer_out     = proc_timer_out;
  assign proc_clk_internal = config_reg[CFG_CLK_INTERNAL];

  // Target request lines blocked out of circuit
  always_comb begin
    {proc_dma_req, proc_timer_in, proc_int_req} =
      filt_reg[NSYNC-1:4] & {(NSYNC-4){in_circuit}};
  end

  // Register read-back
  always_ff @(posedge clk) begin
    if (!rst_b) readdata <= 32'h00000000;
    else if (rd_take) begin
      case (address)
        OFS_CONFIG: readdata <= {16'h0000, config_reg};
        OFS_UPPER:  readdata <= {20'h00000, upper_reg, 8'h00};
        OFS_DATA:
          case (sel)
            SEL_SELF_CHECK: readdata <= {16'h0000, self_check_reg};
            SEL_MAP_RAM:
              readdata <= {31'h00000000, map_ram[map_wr_idx]};
            SEL_JAM_RAM:    readdata <= {16'h0000, jam_ram[upper_reg]};
            default:        readdata <= {29'h00000000, verify_reg};
          endcase
        OFS_STATUS:
          readdata <= {26'h0000000, proc_hold, emu_bus_grant,
                       tgt_bus_grant, brk_reg != BRK_IDLE,
                       queue_mode, in_circuit};
        default:    readdata <= 32'h00000000;
      endcase
    end
  end

endmodule

/* test/pod_assertions.sv */
// Port checks on the emulator pod control block
module pod_assertions
  import pod_pkg::*;
#(
  parameter int CS_WIDTH  = 10,
  parameter int TMR_WIDTH = 2,
  parameter int DMA_WIDTH = 2,
  parameter int IRQ_WIDTH = 4
) (
  // Clock, reset, bus and control inputs
  input wire logic clk, rst_b, read, write, waitrequest, in_circuit_detector,
  input wire logic [3:0] address,
  input wire logic [31:0] writedata,
  input wire logic [2:0] cycle_status_lines,
  input wire logic queue_state_bit0, queue_state_bit1, tgt_rd_b_in, tgt_nmi,
  input wire logic emu_bus_req, tgt_bus_req, break_request,
  // Watched outputs
  input wire logic [DMA_WIDTH-1:0] proc_dma_req,
  input wire logic [TMR_WIDTH-1:0] proc_timer_in, proc_timer_out, tgt_timer_out,
  input wire logic [IRQ_WIDTH-1:0] proc_int_req,
  input wire logic [CS_WIDTH-1:0] proc_chip_sel_b, tgt_chip_sel_b,
  input wire logic proc_clk_internal, tgt_rd_b_out, tgt_rd_b_oe, tgt_ale_qs0,
  input wire logic tgt_wr_qs1, regenerated_latch_strobe, card_xcvr_oe,
  input wire logic proc_hold, tgt_bus_grant, emu_bus_grant, proc_nmi,
  input wire logic tgt_xcvr_oe, tgt_xcvr_to_target
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Passive status followed by an active one
  sequence cyc_start_s;
    cycle_status_lines == CS_PASSIVE ##1
      (cycle_status_lines != CS_PASSIVE && cycle_status_lines != CS_HALT);
  endsequence

  gate_inputs_a: assert property (!in_circuit_detector [*5] |->
    proc_dma_req == '0 && proc_timer_in == '0 && proc_int_req == '0)
    else $error("target inputs pass while out of circuit");
  forward_out_a: assert property (tgt_chip_sel_b == proc_chip_sel_b &&
    tgt_timer_out == proc_timer_out) else $error("outputs not forwarded");
  single_wait_a: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("bus wait longer than one cycle");
  clock_select_a: assert property (write && !waitrequest &&
    address == OFS_CONFIG |=> proc_clk_internal ==
    $past(writedata[CFG_CLK_INTERNAL])) else $error("clock source wrong");
  grant_hold_a: assert property ((tgt_bus_grant || emu_bus_grant) |->
    proc_hold && !(tgt_bus_grant && emu_bus_grant))
    else $error("grant without hold or both granted");
  latch_pulse_a: assert property (cyc_start_s |=>
    regenerated_latch_strobe ##1 !regenerated_latch_strobe)
    else $error("latch strobe not one cycle after start");
  map_settle_a: assert property (cyc_start_s ##0 tgt_rd_b_in |=>
    tgt_rd_b_out [*2]) else $error("read strobe before lookup");
  qualify_a: assert property (cyc_start_s ##0 (tgt_rd_b_in &&
    cycle_status_lines == CS_MEM_RD) |-> ##[2:5] (!tgt_rd_b_out || card_xcvr_oe))
    else $error("read cycle not steered");
  queue_pins_a: assert property ((in_circuit_detector && !tgt_rd_b_in)
    [*8] |-> !tgt_rd_b_oe && tgt_ale_qs0 == $past(queue_state_bit0) &&
    tgt_wr_qs1 == $past(queue_state_bit1)) else $error("queue bits not shown");
  break_nmi_a: assert property ($rose(break_request) && !tgt_nmi
    |-> ##[1:4] proc_nmi) else $error("break gives no processor interrupt");
  target_xcvr_a: assert property (!tgt_rd_b_out |-> tgt_xcvr_oe &&
    !tgt_xcvr_to_target) else $error("target transceiver not turned");
endmodule

/* test/target_model.sv */
// Target system model: read line and bus owner acknowledge
module target_model (
  // Bench controls
  input  wire logic       clk,
  input  wire logic       tie_rd_low,
  input  wire logic [1:0] ack_lag,
  // Pod side
  input  wire logic       proc_hold,
  input  wire logic       tgt_rd_b_out,
  input  wire logic       tgt_rd_b_oe,
  output logic            tgt_rd_b_in,
  output logic            proc_hlda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_pipe = 4'h0;

  // Grounded line wins, pull-up when nobody drives
  assign tgt_rd_b_in = tie_rd_low ? 1'b0 : (tgt_rd_b_oe ? tgt_rd_b_out : 1'b1);
  // Bus released after a chosen lag
  always_ff @(posedge clk) begin
    hold_pipe <= {hold_pipe[2:0], proc_hold};
  end
  assign proc_hlda = hold_pipe[ack_lag];
endmodule

/* test/tb_top.sv */
// Self-checking bench for the emulator pod control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pod_pkg::*;
  logic        clk, rst_b, read, write, waitrequest, in_circuit_detector;
  logic        tgt_nmi, tgt_bus_req, emu_bus_req, break_request, proc_nmi;
  logic        queue_state_bit0, queue_state_bit1, tie_rd_low, proc_hold;
  logic        proc_hlda, tgt_rd_b_in, tgt_bus_grant, emu_bus_grant;
  logic        tgt_rd_b_out, tgt_rd_b_oe, tgt_wr_qs1, tgt_ale_qs0, jam_drive;
  logic        regenerated_latch_strobe, proc_clk_internal, tgt_xcvr_oe;
  logic        tgt_xcvr_to_target, card_xcvr_oe, card_xcvr_to_card;
  logic [3:0]  address, tgt_int_req, proc_int_req;
  logic [1:0]  tgt_dma_req, tgt_timer_in, proc_dma_req, proc_timer_in, ack_lag;
  logic [1:0]  proc_timer_out, tgt_timer_out;
  logic [9:0]  proc_chip_sel_b, tgt_chip_sel_b;
  logic [31:0] writedata, readdata, exp_w;
  logic [2:0]  cycle_status_lines;
  logic [19:0] proc_addr;
  logic [15:0] jam_data;
  logic [31:0] exp_rd[$];
  logic [15:0] exp_jam[$];
  int          err_total, cmp_count, cycles, seed;

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  emulator_pod_break_control dut (.*);
  target_model partner (.*);

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Avalon transfer held until waitrequest is seen low
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // One processor bus cycle framed by passive status
  task automatic cyc(logic [2:0] st, logic [19:0] a);
    cycle_status_lines <= CS_PASSIVE;
    repeat (2) @(posedge clk);
    cycle_status_lines <= st;
    proc_addr <= a;
    repeat (6) @(posedge clk);
    cycle_status_lines <= CS_PASSIVE;
    @(posedge clk);
  endtask
  task automatic wait_hi(ref logic s);
    repeat (30) if (s !== 1'b1) @(posedge clk);
  endtask

  // Result watcher and hang limit
  always @(posedge clk) begin
    // All reads happen outside runs: card side follows host strobes
    if (read && waitrequest === 1'b0 && exp_rd.size() > 0) begin
      chk("readdata", exp_rd.pop_front(), readdata);
      chk("card_xcvr", 32'h3,
          {30'h0, card_xcvr_oe, card_xcvr_to_card});
    end
    if (jam_drive === 1'b1 && exp_jam.size() > 0)
      chk("jam_data", {16'h0, exp_jam.pop_front()},
          {16'h0, jam_data});
    cycles++;
    if (cycles > 20000) begin
      err_total++;
      end_sim();
    end
  end

  // Main sequence
  initial begin
    seed = 96375;
    {read, write, tgt_nmi, tgt_bus_req, emu_bus_req, break_request} = '0;
    {queue_state_bit0, queue_state_bit1, tie_rd_low, in_circuit_detector} = '0;
    {address, writedata, tgt_dma_req, tgt_timer_in, tgt_int_req} = '0;
    {proc_chip_sel_b, proc_timer_out, proc_addr, ack_lag} = '0;
    cycle_status_lines = CS_PASSIVE;
    rst_b = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFS_CONFIG, {16'h0, CFG_RESET});
    rd(4'h1, 32'h0);
    bus(1'b1, OFS_UPPER, 32'h0000_0A00);
    rd(OFS_UPPER, 32'h0000_0A00);
    bus(1'b1, OFS_CONFIG, 32'h0);
    repeat (3) begin
      exp_w = {16'h0, 16'($random(seed))};
      bus(1'b1, OFS_DATA, exp_w);
      rd(OFS_DATA, exp_w);
    end
    // Monitor address, map entries, jam word
    bus(1'b1, OFS_UPPER, 32'h0);
    bus(1'b1, OFS_DATA, 32'h1000);
    bus(1'b1, OFS_CONFIG, 32'h2);
    bus(1'b1, OFS_DATA, 32'h101);
    bus(1'b1, OFS_DATA, 32'h000);
    bus(1'b1, OFS_CONFIG, 32'h4);
    bus(1'b1, OFS_DATA, 32'hC3A5);
    bus(1'b1, OFS_CONFIG, 32'h7);
    // Target inputs blocked, then passed in circuit
    {tgt_dma_req, tgt_timer_in, tgt_int_req} <= 8'($random(seed));
    {proc_chip_sel_b, proc_timer_out} <= 12'($random(seed));
    repeat (8) @(posedge clk);
    in_circuit_detector <= 1'b1;
    repeat (8) @(posedge clk);
    chk("gated", {24'h0, tgt_dma_req, tgt_timer_in, tgt_int_req},
        {24'h0, proc_dma_req, proc_timer_in, proc_int_req});
    cyc(CS_MEM_RD, 20'h01000);
    rd(OFS_DATA, 32'h6);
    cyc(CS_MEM_WR, 20'h00010);
    rd(OFS_DATA, 32'h1);
    // Target grounds its read line
    tie_rd_low <= 1'b1;
    repeat (4) begin
      {queue_state_bit1, queue_state_bit0} <= 2'($random(seed));
      repeat (4) @(posedge clk);
    end
    rd(OFS_STATUS, 32'h3);
    tie_rd_low <= 1'b0;
    // Host then target ownership, prompt and slow acknowledge
    for (int i = 0; i < 2; i++) begin
      ack_lag <= 2'(i * 3);
      emu_bus_req <= 1'b1;
      wait_hi(emu_bus_grant);
      rd(OFS_STATUS, 32'h31);
      emu_bus_req <= 1'b0;
      repeat (10) @(posedge clk);
      tgt_bus_req <= 1'b1;
      wait_hi(tgt_bus_grant);
      rd(OFS_STATUS, 32'h29);
      tgt_bus_req <= 1'b0;
      repeat (10) @(posedge clk);
    end
    // Break jams the stored word on the next fetch
    exp_jam.push_back(16'hC3A5);
    bus(1'b1, OFS_CONFIG, 32'h10);
    break_request <= 1'b1;
    repeat (6) @(posedge clk);
    cyc(CS_FETCH, 20'h00000);
    chk("jam_left", 32'h0, 32'(exp_jam.size()));
    break_request <= 1'b0;
    end_sim();
  end
endmodule

bind emulator_pod_break_control pod_assertions #(.CS_WIDTH(CS_WIDTH),
  .TMR_WIDTH(TMR_WIDTH), .DMA_WIDTH(DMA_WIDTH), .IRQ_WIDTH(IRQ_WIDTH))
  chk_i (.*);
